// ---- deac_params.svh ----
// constants for the data eeprom access control block
`ifndef DEAC_PARAMS_SVH
`define DEAC_PARAMS_SVH

// sector 0 special function register offsets
`define DEAC_OFS_INDIRECT    8'h00
`define DEAC_OFS_PTR_LOW     8'h01
`define DEAC_OFS_PTR_HIGH    8'h02
`define DEAC_OFS_ADDR        8'h10
`define DEAC_OFS_DATA        8'h11
`define DEAC_OFS_FLAG        8'h12

// pointer value that selects eeprom_control in sector 1
`define DEAC_CTRL_PTR_LOW    8'h40
`define DEAC_CTRL_PTR_HIGH   8'h01

// eeprom_control field positions
`define DEAC_BIT_RD_START    0
`define DEAC_BIT_RD_EN       1
`define DEAC_BIT_WR_START    2
`define DEAC_BIT_WR_EN       3
// eeprom_interrupt_flag register field position
`define DEAC_BIT_FLAG        0

// reset values
`define DEAC_RST_BYTE        8'h00
`define DEAC_RST_ADDR        6'h00

// array geometry
`define DEAC_ADDR_W          6
`define DEAC_DEPTH           64

// timing
`define DEAC_CLK_MHZ         100
`define DEAC_READ_TIME_NS    40
`define DEAC_WRITE_TIME_US   2000
`define DEAC_READ_CYCLES     ((`DEAC_READ_TIME_NS * `DEAC_CLK_MHZ + 999) / 1000)
`define DEAC_WRITE_CYCLES    (`DEAC_WRITE_TIME_US * `DEAC_CLK_MHZ)

`endif

// ---- deac_pkg.sv ----
// types for the data eeprom access control block
package deac_pkg;

    typedef enum logic [2:0] {
        DEAC_IDLE  = 3'h1,
        DEAC_READ  = 3'h2,
        DEAC_WRITE = 3'h4
    } deac_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } deac_sfr_req_s;

endpackage : deac_pkg

// ---- deac_timer.sv ----
// down counter that times one eeprom operation
`timescale 1ns/1ps
module deac_timer #(
    parameter int unsigned CYCLES = 4
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic start_i,
    input  wire logic abort_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam int unsigned W = $clog2(CYCLES + 1);

    logic [W-1:0] count;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            count  <= '0;
            done_o <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o <= 1'b0;
            if (abort_i)
                count <= '0;
            else if (start_i)
                count <= W'(CYCLES);
            else if (count != '0)
            begin
                count <= count - W'(1);
                if (count == W'(1))
                    done_o <= 1'b1;
            end
        end
    end

    assign busy_o = (count != '0);

endmodule : deac_timer

// ---- deac_top.sv ----
// data eeprom access sequencer with its special function registers
`timescale 1ns/1ps
`include "deac_params.svh"

// What this block and its software do
// R1: software keeps write enable cleared except while launching a write.
// R2: control register sits in sector 1, unreachable unless pointer high byte selects it.
// R3: software may read a written byte back to check it; optional.
// R4: write start must be set in the instruction right after write enable; the code launches on any later control write while write enable is stored.
// R5: software disables global interrupts around launching a write.
// R6: idle or sleep during an operation makes that operation fail.
// R7: control register reached indirectly with pointer low 40H and high 01H.
// R8: control bit 1 is read enable, bit 0 read start.
// R9: control bit 3 is write enable, bit 2 write start.
// R10: read start reads high during a read, hardware clears it at the end.
// R11: write start stays high for the timed write, hardware clears it after.
// R12: after clearing the control register, reads and writes are disabled.
// R13: a start bit does nothing unless its enable was already set.
// R14: write end sets eeprom flag and multi-function flag; software clears eeprom flag.
// R15: 64 bytes, six-bit address, one byte per operation.
// R16: data register holds the fetched byte until the next operation.
// R17: write duration from a parameterised timer, completion back on the system clock.
module deac_top #(
    parameter int unsigned READ_CYCLES  = `DEAC_READ_CYCLES,
    parameter int unsigned WRITE_CYCLES = `DEAC_WRITE_CYCLES,
    parameter int unsigned ADDR_W       = `DEAC_ADDR_W,
    parameter int unsigned DEPTH        = `DEAC_DEPTH
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ce_i,
    input  wire deac_pkg::deac_sfr_req_s sfr_req_i,
    input  wire logic                   power_down_i,
    output logic [7:0]                  sfr_rdata_o,
    output logic                        sfr_rvalid_o,
    output logic                        eeprom_interrupt_flag_o,
    output logic                        multi_func_flag_set_o,
    output logic                        busy_o
);

    ////////////////////////////////////////////////////////////////////////////
    // storage and state
    logic [7:0]              mem [DEPTH];
    deac_pkg::deac_state_e   state;
    deac_pkg::deac_state_e   next_state;
    logic [7:0]              pointer_low_byte;
    logic [7:0]              pointer_high_byte;
    logic [ADDR_W-1:0]       eeprom_address_register;
    logic [7:0]              eeprom_data_register;
    logic                    read_enable_bit;
    logic                    write_enable_bit;
    logic [ADDR_W-1:0]       op_addr;
    logic [7:0]              op_data;
    logic                    ctrl_sel;
    logic                    ctrl_wr;
    logic                    rd_go;
    logic                    wr_go;
    logic                    abort_op;
    logic                    rd_done;
    logic                    wr_done;
    logic [7:0]              ctrl_view;
    logic [7:0]              next_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // indirect decode and launch conditions
    // control register answers only when the pointer pair selects it
    assign ctrl_sel = (sfr_req_i.addr == `DEAC_OFS_INDIRECT)
                   && (pointer_high_byte == `DEAC_CTRL_PTR_HIGH)         // R2
                   && (pointer_low_byte == `DEAC_CTRL_PTR_LOW);          // R7
    assign ctrl_wr  = sfr_req_i.wr && ctrl_sel;

    // start needs the enable already stored; both starts at once launch nothing
    assign rd_go = ctrl_wr && sfr_req_i.wdata[`DEAC_BIT_RD_START]
                && read_enable_bit                                        // R13
                && !sfr_req_i.wdata[`DEAC_BIT_WR_START]
                && (state == deac_pkg::DEAC_IDLE) && !power_down_i;       // R8
    assign wr_go = ctrl_wr && sfr_req_i.wdata[`DEAC_BIT_WR_START]
                && write_enable_bit                                       // R13
                && !sfr_req_i.wdata[`DEAC_BIT_RD_START]
                && (state == deac_pkg::DEAC_IDLE) && !power_down_i;       // R9 R4

    // entering a low-power mode kills the operation in flight
    assign abort_op = power_down_i && (state != deac_pkg::DEAC_IDLE);     // R6

    ////////////////////////////////////////////////////////////////////////////
    // operation timers
    deac_timer #(
        .CYCLES (READ_CYCLES)
    ) u_read_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .start_i (rd_go),
        .abort_i (abort_op),
        .busy_o  (),
        .done_o  (rd_done)
    );

    deac_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_write_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .start_i (wr_go),
        .abort_i (abort_op),
        .busy_o  (),
        .done_o  (wr_done)                                                // R17
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            deac_pkg::DEAC_IDLE:
            begin
                if (rd_go)
                    next_state = deac_pkg::DEAC_READ;
                else if (wr_go)
                    next_state = deac_pkg::DEAC_WRITE;
            end
            deac_pkg::DEAC_READ:
            begin
                if (abort_op || rd_done)
                    next_state = deac_pkg::DEAC_IDLE;                     // R10
            end
            deac_pkg::DEAC_WRITE:
            begin
                if (abort_op || wr_done)
                    next_state = deac_pkg::DEAC_IDLE;                     // R11
            end
            default:
                next_state = deac_pkg::DEAC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            state <= deac_pkg::DEAC_IDLE;
        else if (ce_i)
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer pair
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pointer_low_byte  <= `DEAC_RST_BYTE;
            pointer_high_byte <= `DEAC_RST_BYTE;
        end
        else if (ce_i && sfr_req_i.wr)
        begin
            if (sfr_req_i.addr == `DEAC_OFS_PTR_LOW)
                pointer_low_byte <= sfr_req_i.wdata;
            else if (sfr_req_i.addr == `DEAC_OFS_PTR_HIGH)
                pointer_high_byte <= sfr_req_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable bits
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            read_enable_bit  <= 1'b0;
            write_enable_bit <= 1'b0;
        end
        else if (ce_i && ctrl_wr)
        begin
            read_enable_bit  <= sfr_req_i.wdata[`DEAC_BIT_RD_EN];        // R12
            write_enable_bit <= sfr_req_i.wdata[`DEAC_BIT_WR_EN];        // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address and data registers
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            eeprom_address_register <= `DEAC_RST_ADDR;
        else if (ce_i && sfr_req_i.wr && sfr_req_i.addr == `DEAC_OFS_ADDR)
            eeprom_address_register <= sfr_req_i.wdata[ADDR_W-1:0];      // R15
    end

    // fetched byte wins over a software write in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            eeprom_data_register <= `DEAC_RST_BYTE;
        else if (ce_i)
        begin
            if (rd_done && state == deac_pkg::DEAC_READ && !abort_op)
                eeprom_data_register <= mem[op_addr];                     // R16
            else if (sfr_req_i.wr && sfr_req_i.addr == `DEAC_OFS_DATA)
                eeprom_data_register <= sfr_req_i.wdata;
        end
    end

    // address and data frozen at launch for the whole operation
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            op_addr <= `DEAC_RST_ADDR;
            op_data <= `DEAC_RST_BYTE;
        end
        else if (ce_i && (rd_go || wr_go))
        begin
            op_addr <= eeprom_address_register;
            op_data <= eeprom_data_register;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // eeprom array
    always_ff @(posedge clk_i)
    begin
        if (ce_i && wr_done && state == deac_pkg::DEAC_WRITE && !abort_op)
            mem[op_addr] <= op_data;                                      // R15
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion flags
    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            eeprom_interrupt_flag_o <= 1'b0;
            multi_func_flag_set_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            multi_func_flag_set_o <= wr_done && !abort_op;                // R14
            if (wr_done && !abort_op)
                eeprom_interrupt_flag_o <= 1'b1;                          // R14
            else if (sfr_req_i.wr && sfr_req_i.addr == `DEAC_OFS_FLAG)
                eeprom_interrupt_flag_o <= sfr_req_i.wdata[`DEAC_BIT_FLAG];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read-back path
    // start bits mirror the running operation; upper nibble reads zero
    always_comb
    begin
        ctrl_view = `DEAC_RST_BYTE;
        ctrl_view[`DEAC_BIT_RD_START] = (state == deac_pkg::DEAC_READ);   // R10
        ctrl_view[`DEAC_BIT_RD_EN]    = read_enable_bit;
        ctrl_view[`DEAC_BIT_WR_START] = (state == deac_pkg::DEAC_WRITE);  // R11
        ctrl_view[`DEAC_BIT_WR_EN]    = write_enable_bit;
    end

    always_comb
    begin
        next_rdata = `DEAC_RST_BYTE;
        if (sfr_req_i.addr == `DEAC_OFS_INDIRECT)
        begin
            if (ctrl_sel)
                next_rdata = ctrl_view;
        end
        else if (sfr_req_i.addr == `DEAC_OFS_PTR_LOW)
            next_rdata = pointer_low_byte;
        else if (sfr_req_i.addr == `DEAC_OFS_PTR_HIGH)
            next_rdata = pointer_high_byte;
        else if (sfr_req_i.addr == `DEAC_OFS_ADDR)
            next_rdata = 8'(eeprom_address_register);
        else if (sfr_req_i.addr == `DEAC_OFS_DATA)
            next_rdata = eeprom_data_register;
        else if (sfr_req_i.addr == `DEAC_OFS_FLAG)
            next_rdata[`DEAC_BIT_FLAG] = eeprom_interrupt_flag_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sfr_rdata_o  <= `DEAC_RST_BYTE;
            sfr_rvalid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sfr_rvalid_o <= sfr_req_i.rd;
            if (sfr_req_i.rd)
                sfr_rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status outputs
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            busy_o <= 1'b0;
        else if (ce_i)
            busy_o <= (next_state != deac_pkg::DEAC_IDLE);
    end

endmodule : deac_top

// ---- deac_top_sva.sv ----
// assertions on the eeprom access sequencer ports
`timescale 1ns/1ps
module deac_top_sva (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    input  wire deac_pkg::deac_sfr_req_s sfr_req_i,
    input  wire logic                    power_down_i,
    input  wire logic [7:0]              sfr_rdata_o,
    input  wire logic                    sfr_rvalid_o,
    input  wire logic                    eeprom_interrupt_flag_o,
    input  wire logic                    multi_func_flag_set_o,
    input  wire logic                    busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic ctrl_wr;
    assign ctrl_wr = sfr_req_i.wr && ce_i && (sfr_req_i.addr == 8'h00);

    ////////////////////////////////////////////////////////////////////////
    property p_read_answer;
        sfr_req_i.rd && ce_i |=> sfr_rvalid_o;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    property p_rdata_hold;
        !(sfr_req_i.rd && ce_i) |=> $stable(sfr_rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    property p_launch_cause;
        $rose(busy_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
    endproperty
    a_launch_cause: assert property (p_launch_cause) else $error("busy without control write");

    property p_abort;
        busy_o && power_down_i && ce_i |-> ##[1:2] !busy_o;
    endproperty
    a_abort: assert property (p_abort) else $error("power down did not abort");

    property p_abort_no_flag;
        busy_o && power_down_i && ce_i |=> !multi_func_flag_set_o [*2];
    endproperty
    a_abort_no_flag: assert property (p_abort_no_flag) else $error("aborted write completed");

    property p_mf_pulse;
        multi_func_flag_set_o && ce_i && $past(ce_i) |=> !multi_func_flag_set_o;
    endproperty
    a_mf_pulse: assert property (p_mf_pulse) else $error("completion pulse too long");

    property p_mf_flag;
        multi_func_flag_set_o && $past(ce_i) |-> eeprom_interrupt_flag_o && $past(busy_o);
    endproperty
    a_mf_flag: assert property (p_mf_flag) else $error("completion without flag");

    property p_flag_hold;
        eeprom_interrupt_flag_o && !(sfr_req_i.wr && ce_i && sfr_req_i.addr == 8'h12)
            |=> eeprom_interrupt_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by itself");
endmodule : deac_top_sva

// ---- deac_bench.sv ----
// self-checking bench for the eeprom access sequencer
`timescale 1ns/1ps
`include "deac_params.svh"
module deac_bench;
    localparam int unsigned WR_CYC = 20;
    logic                    clk_i;
    logic                    rst_n_i;
    logic                    ce_i;
    logic                    power_down_i;
    deac_pkg::deac_sfr_req_s req;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    flag;
    logic                    mf;
    logic                    busy;
    int                      n_fail;
    int                      n_tests;

    deac_top #(.READ_CYCLES(4), .WRITE_CYCLES(WR_CYC)) deac_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sfr_req_i(req),
        .power_down_i(power_down_i), .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid),
        .eeprom_interrupt_flag_o(flag), .multi_func_flag_set_o(mf), .busy_o(busy)
    );

    always #5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one register access, held for exactly one taken edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        req = '0;
    endtask : acc

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        check({7'h00, rvalid}, 8'h01);
        check(rdata, exp);
    endtask : rd_chk

    task automatic wait_idle(output int n);
        n = 0;
        while (busy === 1'b1 && n < 1000)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 1000)
        begin
            n_fail++;
            final_report();
        end
    endtask : wait_idle

    task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
        acc(1'b1, `DEAC_OFS_PTR_LOW, lo);
        acc(1'b1, `DEAC_OFS_PTR_HIGH, hi);
    endtask : set_ptr

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        rd_chk(`DEAC_OFS_ADDR, 8'h00);
        rd_chk(`DEAC_OFS_DATA, 8'h00);
        rd_chk(`DEAC_OFS_FLAG, 8'h00);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h00);
        rd_chk(8'h33, 8'h00);
    endtask : t_reset_vals

    task automatic t_pointer_gate;
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h0A);
        set_ptr(8'h01, 8'h41);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h0A);
        set_ptr(8'h01, 8'h40);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h00);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h0C);
        @(posedge clk_i);
        #1;
        check({7'h00, busy}, 8'h00);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h08);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h02);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h02);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h00);
    endtask : t_pointer_gate

    task automatic t_write(input logic [7:0] a, input logic [7:0] d);
        int n;
        acc(1'b1, `DEAC_OFS_ADDR, a);
        acc(1'b1, `DEAC_OFS_DATA, d);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h08);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h0C);
        @(posedge clk_i);
        #1;
        rd_chk(`DEAC_OFS_INDIRECT, 8'h0C);
        wait_idle(n);
        check({6'h00, mf, flag}, 8'h03);
        n = n + 3;
        check({7'h00, n >= WR_CYC && n <= WR_CYC + 4}, 8'h01);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h08);
        check({6'h00, mf, flag}, 8'h01);
        rd_chk(`DEAC_OFS_FLAG, 8'h01);
        acc(1'b1, `DEAC_OFS_FLAG, 8'h00);
        rd_chk(`DEAC_OFS_FLAG, 8'h00);
        check({7'h00, flag}, 8'h00);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h00);
    endtask : t_write

    task automatic t_read(input logic [7:0] a, input logic [7:0] exp);
        int n;
        acc(1'b1, `DEAC_OFS_ADDR, a);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h02);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h03);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h03);
        wait_idle(n);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h02);
        rd_chk(`DEAC_OFS_DATA, exp);
        rd_chk(`DEAC_OFS_ADDR, a);
        rd_chk(`DEAC_OFS_DATA, exp);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h00);
    endtask : t_read

    task automatic t_disabled;
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h01);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h04);
        @(posedge clk_i);
        #1;
        check({7'h00, busy}, 8'h00);
        rd_chk(`DEAC_OFS_INDIRECT, 8'h00);
    endtask : t_disabled

    task automatic t_abort;
        int n;
        acc(1'b1, `DEAC_OFS_ADDR, 8'h3F);
        acc(1'b1, `DEAC_OFS_DATA, 8'hFF);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h08);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h0C);
        repeat (3) @(posedge clk_i);
        #1;
        power_down_i = 1'b1;
        wait_idle(n);
        check({7'h00, n <= 3}, 8'h01);
        power_down_i = 1'b0;
        rd_chk(`DEAC_OFS_FLAG, 8'h00);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h00);
        t_read(8'h3F, 8'hA5);
    endtask : t_abort

    // clock enable low freezes a running write
    task automatic t_freeze;
        int n;
        acc(1'b1, `DEAC_OFS_ADDR, 8'h01);
        acc(1'b1, `DEAC_OFS_DATA, 8'hC3);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h08);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h0C);
        ce_i = 1'b0;
        repeat (2 * WR_CYC) @(posedge clk_i);
        #1;
        check({6'h00, busy, mf}, 8'h02);
        ce_i = 1'b1;
        wait_idle(n);
        check({6'h00, mf, flag}, 8'h03);
        check({7'h00, n >= WR_CYC && n <= WR_CYC + 4}, 8'h01);
        acc(1'b1, `DEAC_OFS_FLAG, 8'h00);
        acc(1'b1, `DEAC_OFS_INDIRECT, 8'h00);
        t_read(8'h01, 8'hC3);
    endtask : t_freeze

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        power_down_i = 1'b0;
        req = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        t_reset_vals();
        t_pointer_gate();
        t_write(8'h3F, 8'hA5);
        t_write(8'h00, 8'h5A);
        t_read(8'h3F, 8'hA5);
        t_read(8'h00, 8'h5A);
        t_disabled();
        t_abort();
        t_freeze();
        final_report();
    end
endmodule : deac_bench

bind deac_top deac_top_sva deac_top_sva_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sfr_req_i(sfr_req_i),
    .power_down_i(power_down_i), .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o),
    .eeprom_interrupt_flag_o(eeprom_interrupt_flag_o),
    .multi_func_flag_set_o(multi_func_flag_set_o), .busy_o(busy_o)
);
